/* File: rtl/cmal_core.sv */
// Mode selection, address forming and operation timing of the cpu core
`timescale 1ns/1ps
module cmal_core import cmal_pkg::*; #(
   parameter bit SMALL_MODE_AVAIL = 1'b0
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Mode pins
   input  wire logic [1:0] mode_pins_i,
   // Operation request
   input  wire logic       req_valid_i,
   input  wire cmal_req_t  req_i,
   output logic            req_ready_o,
   // Core status inputs
   input  wire logic [1:0] icm_i,
   input  wire logic       wake_i,
   // Operation answer
   output logic            resp_valid_o,
   output cmal_resp_t      resp_o,
   // Core state
   output logic            mode_large_o,
   output logic            sleep_o,
   output logic            irq_mask_o
);

   logic [1:0]  md_s1_r;
   logic [1:0]  md_s2_r;
   logic [1:0]  lock_cnt_r;
   logic        locked_r;
   logic        mode_large_r;
   logic        ready_r;
   logic        resp_valid_r;
   cmal_resp_t  resp_r;
   logic        sleep_r;
   logic        sleep_nxt;
   logic [1:0]  mask_cnt_r;
   logic        irq_mask_r;
   logic [63:0] acc_r;
   logic [63:0] acc_nxt;

   logic        accept_w;
   cmal_op_t    last_op_w;
   logic        done_w;
   logic        idle_nxt_w;
   logic        small_sel_w;
   logic        large_w;
   logic [4:0]  states_w;
   logic [31:0] result_w;
   logic [31:0] ea_full_w;
   logic [23:0] ea_w;

   logic [31:0] sum_w;
   logic [31:0] diff_w;
   logic [31:0] size_mask_w;
   logic [15:0] mulu_b_w;
   logic [31:0] mulu_w_w;
   logic [15:0] muls_b_w;
   logic [31:0] muls_w_w;
   logic [15:0] divb_q_w;
   logic [15:0] divb_r_w;
   logic [31:0] divw_q_w;
   logic [31:0] divw_r_w;
   logic [31:0] mac_prod_w;
   logic [63:0] acc_add_w;
   logic [31:0] frame_bytes_w;
   logic [31:0] call_bytes_w;
   logic [31:0] exc_sp_w;
   logic [31:0] call_sp_w;
   logic [31:0] vec_addr_w;
   logic [31:0] branch_tgt_w;
   logic [31:0] ind_addr_w;
   logic [31:0] fetch_addr_w;

   // Mode pins pass two flops before use
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         md_s1_r <= 2'h0;
         md_s2_r <= 2'h0;
      end else begin
         md_s1_r <= mode_pins_i;
         md_s2_r <= md_s1_r;
      end
   end

   // Mode is caught once the synchroniser has settled after reset
   assign small_sel_w = SMALL_MODE_AVAIL && (md_s2_r == CMAL_MD_SMALL_SEL);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lock_cnt_r   <= 2'h0;
         locked_r     <= 1'b0;
         mode_large_r <= 1'b1;
      end else if (!locked_r) begin
         lock_cnt_r <= lock_cnt_r + 2'h1;
         if (lock_cnt_r == CMAL_LOCK_CNT) begin
            locked_r     <= 1'b1;
            mode_large_r <= !small_sel_w;
         end
      end
   end

   assign large_w  = mode_large_r;
   assign accept_w = req_valid_i && ready_r;

   // Address truncation per mode
   function automatic logic [23:0] cmal_trunc(input logic [31:0] v, input logic lg);
      cmal_trunc = lg ? v[23:0] : {8'h00, v[15:0]};
   endfunction

   // Arithmetic
   assign sum_w    = req_i.a + req_i.b;
   assign diff_w   = req_i.a - req_i.b;
   assign size_mask_w = (req_i.size == CMAL_SZ_B) ? 32'h000000FF :
                        (req_i.size == CMAL_SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF;
   assign mulu_b_w = req_i.a[7:0] * req_i.b[7:0];
   assign mulu_w_w = req_i.a[15:0] * req_i.b[15:0];
   assign muls_b_w = 16'($signed(req_i.a[7:0]) * $signed(req_i.b[7:0]));
   assign muls_w_w = 32'($signed(req_i.a[15:0]) * $signed(req_i.b[15:0]));
   assign divb_q_w = req_i.a[15:0] / {8'h00, req_i.b[7:0]};
   assign divb_r_w = req_i.a[15:0] % {8'h00, req_i.b[7:0]};
   assign divw_q_w = req_i.a / {16'h0000, req_i.b[15:0]};
   assign divw_r_w = req_i.a % {16'h0000, req_i.b[15:0]};

   // Accumulator
   assign mac_prod_w = 32'($signed(req_i.a[15:0]) * $signed(req_i.b[15:0]));
   assign acc_add_w  = acc_r + {{32{mac_prod_w[31]}}, mac_prod_w};

   // Stack frames, register seven carries the stack pointer in c
   assign frame_bytes_w = CMAL_FRAME_BASE + ((icm_i != CMAL_ICM_ZERO) ? CMAL_FRAME_EXR : 32'h0);
   assign call_bytes_w  = large_w ? CMAL_CALL_L : CMAL_CALL_S;
   assign exc_sp_w      = req_i.c - frame_bytes_w;
   assign call_sp_w     = req_i.c - call_bytes_w;

   // Vector and indirect branch addressing
   assign vec_addr_w   = large_w ? (CMAL_VEC_BASE_L + {22'h0, req_i.a[7:0], 2'b00})
                                 : (CMAL_VEC_BASE_S + {23'h0, req_i.a[7:0], 1'b0});
   assign branch_tgt_w = large_w ? {8'h00, req_i.a[23:0]}
                                 : {16'h0000, req_i.a[15:0]};
   assign ind_addr_w   = {24'h000000, req_i.a[7:0]};
   assign fetch_addr_w = {8'h00, req_i.a[23:1], 1'b0};

   // Result, address and state count per operation
   always_comb begin
      result_w  = 32'h0;
      ea_full_w = 32'h0;
      states_w  = CMAL_ST_BASIC;
      unique case (req_i.op)
         CMAL_OP_ADD: begin
            result_w = sum_w & size_mask_w;
            states_w = CMAL_ST_ADD;
         end
         CMAL_OP_SUB: begin
            result_w = diff_w & size_mask_w;
            states_w = CMAL_ST_ADD;
         end
         CMAL_OP_MULU_B: begin
            result_w = {16'h0000, mulu_b_w};
            states_w = CMAL_ST_MULU_B;
         end
         CMAL_OP_MULU_W: begin
            result_w = mulu_w_w;
            states_w = CMAL_ST_MULU_W;
         end
         CMAL_OP_MULS_B: begin
            result_w = {16'h0000, muls_b_w};
            states_w = CMAL_ST_MULS_B;
         end
         CMAL_OP_MULS_W: begin
            result_w = muls_w_w;
            states_w = CMAL_ST_MULS_W;
         end
         CMAL_OP_DIVU_B: begin
            result_w = (req_i.b[7:0] == 8'h00) ? req_i.a : {16'h0000, divb_r_w[7:0], divb_q_w[7:0]};
            states_w = CMAL_ST_DIV_B;
         end
         CMAL_OP_DIVU_W: begin
            result_w = (req_i.b[15:0] == 16'h0000) ? req_i.a : {divw_r_w[15:0], divw_q_w[15:0]};
            states_w = CMAL_ST_DIV_W;
         end
         CMAL_OP_EA_CALC: begin
            result_w  = sum_w;
            ea_full_w = sum_w;
         end
         CMAL_OP_POSTINC: begin
            result_w  = sum_w;
            ea_full_w = req_i.a;
         end
         CMAL_OP_PREDEC: begin
            result_w  = diff_w;
            ea_full_w = diff_w;
         end
         CMAL_OP_VEC_ADDR: begin
            result_w  = vec_addr_w;
            ea_full_w = vec_addr_w;
         end
         CMAL_OP_VEC_TARGET, CMAL_OP_IND_TARGET: begin
            result_w  = branch_tgt_w;
            ea_full_w = branch_tgt_w;
         end
         CMAL_OP_IND_ADDR: begin
            result_w  = ind_addr_w;
            ea_full_w = ind_addr_w;
         end
         CMAL_OP_EXC_ENTRY: begin
            result_w  = {req_i.b[7:0], req_i.a[23:0]};
            ea_full_w = exc_sp_w;
         end
         CMAL_OP_CALL: begin
            result_w  = {8'h00, req_i.a[23:0]};
            ea_full_w = call_sp_w;
         end
         CMAL_OP_STORE_ACCUMULATOR_OP: begin
            result_w = req_i.b[0] ? acc_r[63:32] : acc_r[31:0];
         end
         CMAL_OP_CTRL_LOAD, CMAL_OP_CTRL_STORE: begin
            result_w = req_i.a;
         end
         CMAL_OP_FETCH: begin
            result_w  = fetch_addr_w;
            ea_full_w = fetch_addr_w;
         end
         default: begin
            result_w = 32'h0;
         end
      endcase
   end

   assign ea_w = cmal_trunc(ea_full_w, large_w);

   // Accumulator update
   assign acc_nxt = !accept_w ? acc_r :
                    (req_i.op == CMAL_OP_MAC)    ? acc_add_w :
                    (req_i.op == CMAL_OP_CLEAR_ACCUMULATOR_OP) ? 64'h0 :
                    (req_i.op == CMAL_OP_LOAD_ACCUMULATOR_OP && req_i.b[0])  ? {req_i.a, acc_r[31:0]} :
                    (req_i.op == CMAL_OP_LOAD_ACCUMULATOR_OP && !req_i.b[0]) ? {acc_r[63:32], req_i.a} : acc_r;

   cmal_state_timer #(
      .CW (5)
   ) u_timer (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .load_i     (accept_w),
      .count_i    (states_w),
      .done_o     (done_w),
      .idle_nxt_o (idle_nxt_w)
   );

   // One-state operations finish in their accept cycle, before resp_r holds them
   assign last_op_w = accept_w ? req_i.op : resp_r.op;

   // Sleep entry wins over a wake in the same cycle
   assign sleep_nxt = (done_w && last_op_w == CMAL_OP_SLEEP) ? 1'b1 : (wake_i ? 1'b0 : sleep_r);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ready_r      <= 1'b0;
         resp_valid_r <= 1'b0;
         resp_r       <= '0;
         sleep_r      <= 1'b0;
         acc_r        <= 64'h0;
      end else begin
         ready_r      <= locked_r && idle_nxt_w && !sleep_nxt;
         resp_valid_r <= done_w;
         sleep_r      <= sleep_nxt;
         acc_r        <= acc_nxt;
         if (accept_w) begin
            resp_r <= '{op: req_i.op, result: result_w, ea: ea_w};
         end
      end
   end

   // Interrupt mask after a control register load or modify
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mask_cnt_r <= 2'h0;
         irq_mask_r <= 1'b0;
      end else if (done_w && last_op_w == CMAL_OP_CTRL_LOAD) begin
         mask_cnt_r <= CMAL_IRQ_HOLD - 2'h1;
         irq_mask_r <= 1'b1;
      end else if (mask_cnt_r != 2'h0) begin
         mask_cnt_r <= mask_cnt_r - 2'h1;
         irq_mask_r <= 1'b1;
      end else begin
         irq_mask_r <= 1'b0;
      end
   end

   assign req_ready_o  = ready_r;
   assign resp_valid_o = resp_valid_r;
   assign resp_o       = resp_r;
   assign mode_large_o = mode_large_r;
   assign sleep_o      = sleep_r;
   assign irq_mask_o   = irq_mask_r;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_add_one_state: assert property (
      accept_w && req_i.op == CMAL_OP_ADD |-> ##1 resp_valid_o && resp_o.op == CMAL_OP_ADD)
      else $error("add did not finish in one state");

   a_mulu_byte_time: assert property (
      accept_w && req_i.op == CMAL_OP_MULU_B |-> ##1 !resp_valid_o [*2] ##1 resp_valid_o)
      else $error("byte multiply did not take three states");

   a_mulu_word_time: assert property (
      accept_w && req_i.op == CMAL_OP_MULU_W |-> ##1 !resp_valid_o [*3] ##1 resp_valid_o)
      else $error("word multiply did not take four states");

   a_div_byte_time: assert property (
      accept_w && req_i.op == CMAL_OP_DIVU_B |-> ##1 !resp_valid_o [*8] ##3 !resp_valid_o ##1 resp_valid_o)
      else $error("byte divide did not take twelve states");

   a_div_word_time: assert property (
      accept_w && req_i.op == CMAL_OP_DIVU_W |-> ##20 resp_valid_o && resp_o.op == CMAL_OP_DIVU_W)
      else $error("word divide did not take twenty states");

   a_mode_large_only: assert property (
      locked_r && !SMALL_MODE_AVAIL |-> mode_large_o)
      else $error("small mode entered on a device without it");

   a_small_ea_width: assert property (
      resp_valid_o && !mode_large_o |-> resp_o.ea[23:16] == 8'h00)
      else $error("small mode address wider than 16 bits");

   a_fetch_even_addr: assert property (
      resp_valid_o && resp_o.op == CMAL_OP_FETCH |-> !resp_o.ea[0])
      else $error("fetch address is odd");

   a_ind_target_top: assert property (
      resp_valid_o && resp_o.op == CMAL_OP_IND_TARGET && mode_large_o |-> resp_o.result[31:24] == 8'h00)
      else $error("indirect target top byte not zero");

   a_ctrl_irq_mask: assert property (
      resp_valid_o && resp_o.op == CMAL_OP_CTRL_LOAD |-> irq_mask_o [*3])
      else $error("interrupts not masked for three states");

   a_sleep_entry: assert property (
      resp_valid_o && resp_o.op == CMAL_OP_SLEEP |-> sleep_o && !req_ready_o)
      else $error("sleep not entered");

   c_add_done:   cover property (accept_w && req_i.op == CMAL_OP_ADD ##1 resp_valid_o);
   c_div_word:   cover property (accept_w && req_i.op == CMAL_OP_DIVU_W ##20 resp_valid_o);
   c_ctrl_mask:  cover property (resp_valid_o && resp_o.op == CMAL_OP_CTRL_LOAD ##3 !irq_mask_o);
   c_sleep_wake: cover property (sleep_o ##1 wake_i ##1 !sleep_o);

endmodule

/* File: rtl/cmal_pkg.sv */
// Package with types and constants of the cpu mode and address logic
// Overview of operation
// - Register add or subtract of 8, 16 or 32 bits completes in one state.
// - Unsigned byte multiply takes 3 states, unsigned 16 by 16 multiply takes 4 states.
// - Divide 16 by 8 takes 12 states, divide 32 by 16 takes 20 states.
// - Mode pins choose small 64-kbyte mode or large 16-Mbyte mode.
// - Small mode exists only with SMALL_MODE_AVAIL set; without it the core always runs in large mode.
// - Small mode uses only the low 16 bits of each effective address.
// - Small mode leaves the extended half free to hold any value.
// - Small mode carry or borrow of increment or decrement reaches the extended half.
// - Small mode vector table starts at zero with 16-bit entries.
// - Small mode indirect branch uses 8-bit address, reads 16-bit target.
// - Small mode indirect targets lie in 0x0000 to 0x00FF, sharing vector area.
// - Large mode vectors are 32-bit from zero, top byte ignored, 24-bit target.
// - Large mode indirect branch reads 32-bit target with top byte taken as zero.
// - Large mode indirect targets lie in 0x00000000 to 0x000000FF.
// - Exception entry pushes program counter and flags, extended control only if mode nonzero.
// - Multiply-accumulate, clear, load and store accumulator operations are executed.
// - Sleep operation puts the core into its power-down state.
// - Program counter is 24 bits and fetch address lowest bit is zero.
// - Control register load or modify masks all interrupts for three states.
// - General register seven is the stack pointer for calls and exceptions.
package cmal_pkg;

   // Operation codes
   typedef enum logic [4:0] {
      CMAL_OP_ADD,
      CMAL_OP_SUB,
      CMAL_OP_MULU_B,
      CMAL_OP_MULU_W,
      CMAL_OP_MULS_B,
      CMAL_OP_MULS_W,
      CMAL_OP_DIVU_B,
      CMAL_OP_DIVU_W,
      CMAL_OP_EA_CALC,
      CMAL_OP_POSTINC,
      CMAL_OP_PREDEC,
      CMAL_OP_VEC_ADDR,
      CMAL_OP_VEC_TARGET,
      CMAL_OP_IND_ADDR,
      CMAL_OP_IND_TARGET,
      CMAL_OP_EXC_ENTRY,
      CMAL_OP_CALL,
      CMAL_OP_MAC,
      CMAL_OP_CLEAR_ACCUMULATOR_OP,
      CMAL_OP_LOAD_ACCUMULATOR_OP,
      CMAL_OP_STORE_ACCUMULATOR_OP,
      CMAL_OP_CTRL_LOAD,
      CMAL_OP_CTRL_STORE,
      CMAL_OP_SLEEP,
      CMAL_OP_FETCH
   } cmal_op_t;

   typedef enum logic [1:0] {
      CMAL_SZ_B,
      CMAL_SZ_W,
      CMAL_SZ_L
   } cmal_size_t;

   typedef struct packed {
      cmal_op_t    op;
      cmal_size_t  size;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
   } cmal_req_t;

   typedef struct packed {
      cmal_op_t    op;
      logic [31:0] result;
      logic [23:0] ea;
   } cmal_resp_t;

   // State counts per operation
   localparam logic [4:0] CMAL_ST_ADD    = 5'h01;
   localparam logic [4:0] CMAL_ST_MULU_B = 5'h03;
   localparam logic [4:0] CMAL_ST_MULU_W = 5'h04;
   localparam logic [4:0] CMAL_ST_MULS_B = 5'h04;
   localparam logic [4:0] CMAL_ST_MULS_W = 5'h05;
   localparam logic [4:0] CMAL_ST_DIV_B  = 5'h0C;
   localparam logic [4:0] CMAL_ST_DIV_W  = 5'h14;
   localparam logic [4:0] CMAL_ST_BASIC  = 5'h01;
   localparam logic [1:0] CMAL_IRQ_HOLD  = 2'h3;
   localparam logic [1:0] CMAL_LOCK_CNT  = 2'h3;

   // Mode pin code that selects the small mode
   localparam logic [1:0] CMAL_MD_SMALL_SEL = 2'h0;

   // Address layout
   localparam logic [31:0] CMAL_VEC_BASE_S = 32'h00000000;
   localparam logic [31:0] CMAL_VEC_BASE_L = 32'h00000000;
   localparam logic [31:0] CMAL_FRAME_BASE = 32'h00000004;
   localparam logic [31:0] CMAL_FRAME_EXR  = 32'h00000002;
   localparam logic [31:0] CMAL_CALL_S     = 32'h00000002;
   localparam logic [31:0] CMAL_CALL_L     = 32'h00000004;
   localparam logic [1:0]  CMAL_ICM_ZERO   = 2'h0;

endpackage

/* File: rtl/cmal_state_timer.sv */
// State counter that times one operation
`timescale 1ns/1ps
module cmal_state_timer #(
   parameter int CW = 5
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   // Control
   input  wire logic          load_i,
   input  wire logic [CW-1:0] count_i,
   // Status
   output logic               done_o,
   output logic               idle_nxt_o
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   assign cnt_nxt    = load_i ? count_i : ((cnt_r != '0) ? cnt_r - CW'(1) : '0);
   // Done leads the last state by one cycle so the answer flop lands on it
   assign done_o     = (cnt_nxt == CW'(1));
   assign idle_nxt_o = (cnt_nxt == '0);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

/* File: tb/cmal_core_tb.sv */
// Self-checking testbench of the cpu mode and address logic
`timescale 1ns/1ps
module cmal_core_tb import cmal_pkg::*;;
   logic       clk_i;
   logic       nrst_i;
   logic [1:0] mode_pins_i;
   logic       req_valid_i;
   cmal_req_t  req_i;
   logic       req_ready_o;
   logic [1:0] icm_i;
   logic       wake_i;
   logic       resp_valid_o;
   cmal_resp_t resp_o;
   logic       mode_large_o;
   logic       sleep_o;
   logic       irq_mask_o;
   logic [1:0] sm_pins;
   logic       sm_valid;
   cmal_resp_t sm_resp;
   logic       sm_large;
   int         err_total;
   int         n_compared;

   cmal_core DUT (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .mode_pins_i  (mode_pins_i),
      .req_valid_i  (req_valid_i),
      .req_i        (req_i),
      .req_ready_o  (req_ready_o),
      .icm_i        (icm_i),
      .wake_i       (wake_i),
      .resp_valid_o (resp_valid_o),
      .resp_o       (resp_o),
      .mode_large_o (mode_large_o),
      .sleep_o      (sleep_o),
      .irq_mask_o   (irq_mask_o)
   );

   // Second core with the small mode fitted, its pins at the small code
   cmal_core #(
      .SMALL_MODE_AVAIL (1'b1)
   ) DUT_SM (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .mode_pins_i  (sm_pins),
      .req_valid_i  (req_valid_i),
      .req_i        (req_i),
      .req_ready_o  (),
      .icm_i        (icm_i),
      .wake_i       (wake_i),
      .resp_valid_o (sm_valid),
      .resp_o       (sm_resp),
      .mode_large_o (sm_large),
      .sleep_o      (),
      .irq_mask_o   ()
   );

   always #5 clk_i = ~clk_i;

   task automatic final_report();
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic int exp_states(input cmal_op_t op);
      case (op)
         CMAL_OP_MULU_B:                 return 3;
         CMAL_OP_MULU_W, CMAL_OP_MULS_B: return 4;
         CMAL_OP_MULS_W:                 return 5;
         CMAL_OP_DIVU_B:                 return 12;
         CMAL_OP_DIVU_W:                 return 20;
         default:                        return 1;
      endcase
   endfunction

   // Top bit set when the result is defined for this operation
   function automatic logic [32:0] exp_res(input cmal_req_t r, input logic lg);
      logic [31:0] m;
      logic [31:0] s;
      logic [31:0] q;
      logic [31:0] t;
      m = (r.size == CMAL_SZ_B) ? 32'h000000FF : (r.size == CMAL_SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF;
      q = 32'h00000000;
      t = 32'h00000000;
      case (r.op)
         CMAL_OP_ADD:    s = (r.a + r.b) & m;
         CMAL_OP_SUB:    s = (r.a - r.b) & m;
         CMAL_OP_MULU_B: s = 32'(r.a[7:0]) * 32'(r.b[7:0]);
         CMAL_OP_MULU_W: s = 32'(r.a[15:0]) * 32'(r.b[15:0]);
         CMAL_OP_MULS_B: begin
            t = 32'($signed(r.a[7:0])) * 32'($signed(r.b[7:0]));
            s = {16'h0000, t[15:0]};
         end
         CMAL_OP_MULS_W: s = 32'($signed(r.a[15:0])) * 32'($signed(r.b[15:0]));
         CMAL_OP_DIVU_B: begin
            if (r.b[7:0] != 8'h00) begin
               q = 32'(r.a[15:0]) / 32'(r.b[7:0]);
               t = 32'(r.a[15:0]) % 32'(r.b[7:0]);
            end
            s = (r.b[7:0] == 8'h00) ? r.a : {16'h0000, t[7:0], q[7:0]};
         end
         CMAL_OP_DIVU_W: begin
            if (r.b[15:0] != 16'h0000) begin
               q = r.a / 32'(r.b[15:0]);
               t = r.a % 32'(r.b[15:0]);
            end
            s = (r.b[15:0] == 16'h0000) ? r.a : {t[15:0], q[15:0]};
         end
         CMAL_OP_EA_CALC, CMAL_OP_POSTINC:         s = r.a + r.b;
         CMAL_OP_PREDEC:                           s = r.a - r.b;
         CMAL_OP_VEC_TARGET, CMAL_OP_IND_TARGET:   s = lg ? {8'h00, r.a[23:0]} : {16'h0000, r.a[15:0]};
         CMAL_OP_EXC_ENTRY:                        s = {r.b[7:0], r.a[23:0]};
         CMAL_OP_CTRL_LOAD, CMAL_OP_CTRL_STORE:    s = r.a;
         default:                                  return 33'h0;
      endcase
      return {1'b1, s};
   endfunction

   // Top bit set when the address is defined for this operation
   function automatic logic [24:0] exp_ea(input cmal_req_t r, input logic [1:0] icm, input logic lg);
      logic [31:0] s;
      s = r.c - 32'h00000004 - ((icm != 2'h0) ? 32'h00000002 : 32'h00000000);
      case (r.op)
         CMAL_OP_EA_CALC:   s = r.a + r.b;
         CMAL_OP_POSTINC:   s = r.a;
         CMAL_OP_PREDEC:    s = r.a - r.b;
         CMAL_OP_VEC_ADDR:  s = lg ? {22'h0, r.a[7:0], 2'b00} : {23'h0, r.a[7:0], 1'b0};
         CMAL_OP_IND_ADDR:  s = {24'h000000, r.a[7:0]};
         CMAL_OP_EXC_ENTRY: s = s;
         CMAL_OP_CALL:      s = r.c - (lg ? 32'h00000004 : 32'h00000002);
         CMAL_OP_FETCH:     s = {8'h00, r.a[23:1], 1'b0};
         default:           return 25'h0;
      endcase
      return {1'b1, lg ? s[23:0] : {8'h00, s[15:0]}};
   endfunction

   function automatic cmal_req_t mk(input cmal_op_t op, input logic [31:0] a, input logic [31:0] b);
      cmal_req_t r;
      r.op   = op;
      r.size = CMAL_SZ_L;
      r.a    = a;
      r.b    = b;
      r.c    = 32'h00001000;
      return r;
   endfunction

   // One request; returns at the edge where the answer is seen
   task automatic do_op(input cmal_req_t r, input logic [1:0] icm);
      int          n;
      logic [32:0] er;
      logic [24:0] ee;
      logic [32:0] sr;
      logic [24:0] se;
      er = exp_res(r, 1'b1);
      ee = exp_ea(r, icm, 1'b1);
      sr = exp_res(r, 1'b0);
      se = exp_ea(r, icm, 1'b0);
      req_i       <= r;
      icm_i       <= icm;
      req_valid_i <= 1'b1;
      mode_pins_i <= 2'($urandom);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 60);
      if (req_ready_o !== 1'b1) begin
         err_total++;
         final_report();
      end
      req_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (resp_valid_o !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_total++;
         final_report();
      end
      chk(n, exp_states(r.op));
      chk(resp_o.op, r.op);
      if (er[32]) chk(resp_o.result, er[31:0]);
      if (ee[24]) chk(resp_o.ea, ee[23:0]);
      chk(mode_large_o, 1'b1);
      chk(sm_valid, 1'b1);
      chk(sm_large, 1'b0);
      if (sr[32]) chk(sm_resp.result, sr[31:0]);
      if (se[24]) chk(sm_resp.ea, se[23:0]);
   endtask

   cmal_op_t  rops[18] = '{CMAL_OP_ADD, CMAL_OP_SUB, CMAL_OP_MULU_B, CMAL_OP_MULU_W, CMAL_OP_MULS_B,
                           CMAL_OP_MULS_W, CMAL_OP_DIVU_B, CMAL_OP_DIVU_W, CMAL_OP_EA_CALC, CMAL_OP_POSTINC,
                           CMAL_OP_PREDEC, CMAL_OP_VEC_ADDR, CMAL_OP_VEC_TARGET, CMAL_OP_IND_ADDR,
                           CMAL_OP_IND_TARGET, CMAL_OP_EXC_ENTRY, CMAL_OP_CALL, CMAL_OP_FETCH};
   cmal_req_t r;
   int        n;

   initial begin
      clk_i       = 1'b0;
      nrst_i      = 1'b0;
      mode_pins_i = 2'h0;
      req_valid_i = 1'b0;
      req_i       = '0;
      icm_i       = 2'h0;
      wake_i      = 1'b0;
      sm_pins     = 2'h0;
      err_total   = 0;
      n_compared  = 0;
      void'($urandom(76791));
      repeat (16) @(posedge clk_i);
      chk({req_ready_o, mode_large_o, sleep_o, irq_mask_o}, 4'h4);
      nrst_i <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         r = mk(CMAL_OP_ADD, 32'hFFFFFFFF, 32'h00000001);
         r.size = cmal_size_t'(s);
         do_op(r, 2'h0);
      end
      for (int i = 0; i < 180; i++) begin
         r = mk(rops[i % 18], $urandom, $urandom);
         r.c = $urandom;
         r.size = cmal_size_t'($urandom % 3);
         if (r.op == CMAL_OP_DIVU_B) begin
            r.b = (i < 18) ? 32'h00000000 : $urandom % 256;
            if (r.b != 0) r.a = ($urandom % 256) * r.b + $urandom % r.b;
         end
         if (r.op == CMAL_OP_DIVU_W) begin
            r.b = (i < 18) ? 32'h00000000 : $urandom % 65536;
            if (r.b != 0) r.a = ($urandom % 65536) * r.b + $urandom % r.b;
         end
         do_op(r, (i < 18) ? 2'h0 : 2'($urandom));
      end
      // Accumulator load, store, clear and accumulate
      do_op(mk(CMAL_OP_CLEAR_ACCUMULATOR_OP, 32'h0, 32'h0), 2'h0);
      do_op(mk(CMAL_OP_STORE_ACCUMULATOR_OP, 32'h0, 32'h0), 2'h0);
      chk(resp_o.result, 32'h00000000);
      do_op(mk(CMAL_OP_LOAD_ACCUMULATOR_OP, 32'h12345678, 32'h0), 2'h0);
      do_op(mk(CMAL_OP_LOAD_ACCUMULATOR_OP, 32'h9ABCDEF0, 32'h1), 2'h0);
      do_op(mk(CMAL_OP_STORE_ACCUMULATOR_OP, 32'h0, 32'h0), 2'h0);
      chk(resp_o.result, 32'h12345678);
      do_op(mk(CMAL_OP_STORE_ACCUMULATOR_OP, 32'h0, 32'h1), 2'h0);
      chk(resp_o.result, 32'h9ABCDEF0);
      do_op(mk(CMAL_OP_CLEAR_ACCUMULATOR_OP, 32'h0, 32'h0), 2'h0);
      repeat (2) do_op(mk(CMAL_OP_MAC, 32'h3, 32'h5), 2'h0);
      do_op(mk(CMAL_OP_STORE_ACCUMULATOR_OP, 32'h0, 32'h0), 2'h0);
      chk(resp_o.result, 32'h0000001E);
      // Interrupt mask window after a control load only
      do_op(mk(CMAL_OP_CTRL_STORE, 32'h55, 32'h0), 2'h0);
      chk(irq_mask_o, 1'b0);
      do_op(mk(CMAL_OP_CTRL_LOAD, 32'hAA, 32'h0), 2'h0);
      n = 0;
      while (irq_mask_o === 1'b1 && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      chk(n, 3);
      // Sleep refuses requests until woken
      do_op(mk(CMAL_OP_SLEEP, 32'h0, 32'h0), 2'h0);
      chk(sleep_o, 1'b1);
      req_i       <= mk(CMAL_OP_ADD, 32'h1, 32'h1);
      req_valid_i <= 1'b1;
      repeat (6) begin
         @(posedge clk_i);
         chk({sleep_o, req_ready_o, resp_valid_o}, 3'h4);
      end
      req_valid_i <= 1'b0;
      wake_i      <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      @(posedge clk_i);
      chk(sleep_o, 1'b0);
      do_op(mk(CMAL_OP_ADD, 32'h7, 32'h9), 2'h0);
      final_report();
   end
endmodule
